// ### psg_config_bank.sv
// Sequencing, sleep-source, general-output and target-address configuration bank
// Function
// - Falling-delay code in bits 5:3 delays rail-pair disable after enable falls.
// - Rising-delay code in bits 2:0 delays rail-pair enable after enable rises.
// - Code 110 selects 32 ms for both delay fields.
// - Sleep bits 7,6 pick control input three or six for LDO rails.
// - Sleep bits 5..0 pick control input three or six for buck rails.
// - Output-mode bits 7..4 route outputs to power-good logic or host value.
// - Output-mode bits 2..0 pick push-pull or open drain for outputs three..one.
// - Address bit 7 picks fixed default or programmable target address.
`timescale 1ns/10ps
module psg_config_bank #(
  parameter int CYCLES_PER_MS = psg_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // Nonvolatile defaults, loaded after reset release
  input  wire logic       nv_load_i,
  input  wire logic [7:0] nv_pair_delay_i,
  input  wire logic [7:0] nv_sleep_select_i,
  input  wire logic [7:0] nv_output_mode_i,
  input  wire logic [7:0] nv_target_cfg_i,
  // Register port from the I2C engine
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  output logic            reg_hit_o,
  // Rail pair sequencing
  input  wire logic       pair_enable_i,
  output logic            switch_ldo_rail_pair_en_o,
  // Sleep entry
  input  wire logic       control_input_three_i,
  input  wire logic       control_input_six_i,
  output logic [7:0]      rail_sleep_o,
  // General outputs
  input  wire logic [3:0] power_good_i,
  input  wire logic [3:0] host_out_value_i,
  output logic [3:0]      general_out_o,
  output logic [3:0]      general_out_oe_o,
  // Target address for the I2C engine
  output logic [6:0]      target_address_o
);
  logic [7:0] pair_delay;
  logic [7:0] sleep_select;
  logic [7:0] output_mode;
  logic [7:0] target_cfg;
  psg_pkg::psg_state_t state;
  psg_pkg::psg_state_t next_state;
  logic       pair_en_d;
  logic       timer_start;
  logic [6:0] timer_ms;
  logic       timer_done;

  function automatic logic [6:0] code_to_ms(input logic [2:0] code);
    case (code)
      3'h0:    code_to_ms = 7'(psg_pkg::DELAY_MS_0);
      3'h1:    code_to_ms = 7'(psg_pkg::DELAY_MS_1);
      3'h2:    code_to_ms = 7'(psg_pkg::DELAY_MS_2);
      3'h3:    code_to_ms = 7'(psg_pkg::DELAY_MS_3);
      3'h4:    code_to_ms = 7'(psg_pkg::DELAY_MS_4);
      3'h5:    code_to_ms = 7'(psg_pkg::DELAY_MS_5);
      3'h6:    code_to_ms = 7'(psg_pkg::DELAY_MS_6);
      default: code_to_ms = 7'(psg_pkg::DELAY_MS_7);
    endcase
  endfunction

  // Address decode
  wire hit_delay = (reg_addr_i == psg_pkg::ADDR_PAIR_DELAY);
  wire hit_sleep = (reg_addr_i == psg_pkg::ADDR_SLEEP_SELECT);
  wire hit_mode  = (reg_addr_i == psg_pkg::ADDR_OUTPUT_MODE);
  wire hit_addr  = (reg_addr_i == psg_pkg::ADDR_TARGET_CFG);
  assign reg_hit_o = hit_delay | hit_sleep | hit_mode | hit_addr;

  // Write enables; a nonvolatile load masks any host write in its cycle
  wire wr_delay = reg_wr_i & ~nv_load_i & hit_delay;
  wire wr_sleep = reg_wr_i & ~nv_load_i & hit_sleep;
  wire wr_mode  = reg_wr_i & ~nv_load_i & hit_mode;
  wire wr_addr  = reg_wr_i & ~nv_load_i & hit_addr;

  // Full bytes kept, reserved bits included; they drive nothing
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_delay <= 8'h00;
    end else if (nv_load_i) begin
      pair_delay <= nv_pair_delay_i;
    end else if (wr_delay) begin
      pair_delay <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_select <= 8'h00;
    end else if (nv_load_i) begin
      sleep_select <= nv_sleep_select_i;
    end else if (wr_sleep) begin
      sleep_select <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_mode <= 8'h00;
    end else if (nv_load_i) begin
      output_mode <= nv_output_mode_i;
    end else if (wr_mode) begin
      output_mode <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      target_cfg <= 8'h00;
    end else if (nv_load_i) begin
      target_cfg <= nv_target_cfg_i;
    end else if (wr_addr) begin
      target_cfg <= reg_wdata_i;
    end
  end

  wire [7:0] next_rdata = hit_delay ? pair_delay   :
                          hit_sleep ? sleep_select :
                          hit_mode  ? output_mode  :
                          hit_addr  ? target_cfg   : 8'h00;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) reg_rdata_o <= 8'h00;
    else         reg_rdata_o <= next_rdata;
  end

  // Rail pair sequencing: edges of the enable start a delay
  wire [2:0] fall_code = pair_delay[psg_pkg::FALL_LSB +: psg_pkg::DELAY_W];
  wire [2:0] rise_code = pair_delay[psg_pkg::RISE_LSB +: psg_pkg::DELAY_W];
  wire       rise_edge = pair_enable_i & ~pair_en_d;
  wire       fall_edge = ~pair_enable_i & pair_en_d;

  // An opposite edge during a wait restarts the timer with the new delay
  assign timer_start = rise_edge | fall_edge;
  assign timer_ms    = rise_edge ? code_to_ms(rise_code)
                                 : code_to_ms(fall_code);

  always_comb begin
    next_state = state;
    case (state)
      psg_pkg::PSG_OFF:     if (rise_edge) next_state = psg_pkg::PSG_RISE_WT;
      psg_pkg::PSG_RISE_WT: begin
        if (fall_edge)       next_state = psg_pkg::PSG_OFF;
        else if (timer_done) next_state = psg_pkg::PSG_ON;
      end
      psg_pkg::PSG_ON:      if (fall_edge) next_state = psg_pkg::PSG_FALL_WT;
      psg_pkg::PSG_FALL_WT: begin
        if (rise_edge)       next_state = psg_pkg::PSG_ON;
        else if (timer_done) next_state = psg_pkg::PSG_OFF;
      end
      default:              next_state = psg_pkg::PSG_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state     <= psg_pkg::PSG_OFF;
      pair_en_d <= 1'b0;
    end else begin
      state     <= next_state;
      pair_en_d <= pair_enable_i;
    end
  end

  assign switch_ldo_rail_pair_en_o = (state == psg_pkg::PSG_ON) ||
                                     (state == psg_pkg::PSG_FALL_WT);

  psg_delay_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rstn_i   (rstn_i),
    .start_i  (timer_start),
    .ms_i     (timer_ms),
    .done_o   (timer_done)
  );

  // Sleep sources: bit set picks control input six
  wire [7:0] next_sleep = (sleep_select & {8{control_input_six_i}}) |
                          (~sleep_select & {8{control_input_three_i}});

  // General outputs: source then drive; output four is always push-pull
  wire [3:0] out_src   = output_mode[psg_pkg::SRC_LSB +: 4];
  wire [3:0] out_value = (out_src & host_out_value_i) |
                         (~out_src & power_good_i);
  wire [3:0] open_drn  = {1'b0, output_mode[psg_pkg::DRIVE_LSB +: 3]};
  // Open drain drives only a low level
  wire [3:0] next_oe   = ~open_drn | ~out_value;

  wire [6:0] next_target = target_cfg[psg_pkg::ADDR_SEL_BIT] ? target_cfg[6:0]
                                                            : psg_pkg::DEFAULT_TARGET;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rail_sleep_o <= 8'h00;
    end else begin
      rail_sleep_o <= next_sleep;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      general_out_o    <= 4'h0;
      general_out_oe_o <= 4'h0;
    end else begin
      general_out_o    <= out_value;
      general_out_oe_o <= next_oe;
    end
  end

  // Reset value already names the fixed address so the engine answers at once
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      target_address_o <= psg_pkg::DEFAULT_TARGET;
    end else begin
      target_address_o <= next_target;
    end
  end
endmodule

// ### psg_config_bank_props.sv
// Port checker for the config bank
`timescale 1ns/10ps
module psg_config_bank_props #(
  parameter int CYCLES_PER_MS = psg_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  // Register port
  input wire logic       nv_load_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_hit_o,
  // Controlled outputs and their inputs
  input wire logic       pair_enable_i,
  input wire logic       switch_ldo_rail_pair_en_o,
  input wire logic       control_input_three_i,
  input wire logic       control_input_six_i,
  input wire logic [7:0] rail_sleep_o,
  input wire logic [3:0] general_out_oe_o,
  input wire logic [6:0] target_address_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic tw;
  assign tw = reg_wr_i && reg_addr_i == 8'h5F && !nv_load_i;
  chk_addr_select: assert property (tw ##1 !tw && !nv_load_i |=> target_address_o ==
    ($past(reg_wdata_i[7], 2) ? $past(reg_wdata_i[6:0], 2) : 7'h5E)) else $error("addr choice");
  chk_hit_decode: assert property (reg_hit_o == (reg_addr_i inside {8'h27, 8'h29,
    8'h2A, 8'h5F})) else $error("hit decode");
  chk_unmapped_zero: assert property (!reg_hit_o |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  chk_reg_readback: assert property (reg_wr_i && reg_hit_o && !nv_load_i ##1
    $stable(reg_addr_i) && !reg_wr_i && !nv_load_i |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("readback");
  chk_out4_pushpull: assert property ($past(rstn_i, 2) |-> general_out_oe_o[3])
    else $error("out4 drive");
  chk_sleep_follow: assert property ((control_input_three_i ==
    control_input_six_i && $stable(control_input_three_i))[*3] |->
    rail_sleep_o == {8{control_input_three_i}}) else $error("sleep source");
  chk_pair_rise: assert property ($rose(switch_ldo_rail_pair_en_o) |->
    $past(pair_enable_i, 2)) else $error("pair rise");
  chk_pair_fall: assert property ($fell(switch_ldo_rail_pair_en_o) |->
    !$past(pair_enable_i, 2)) else $error("pair fall");
endmodule
bind psg_config_bank psg_config_bank_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
  .sys_clk_i, .rstn_i, .nv_load_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_hit_o, .pair_enable_i, .switch_ldo_rail_pair_en_o, .control_input_three_i,
  .control_input_six_i, .rail_sleep_o, .general_out_oe_o, .target_address_o
);

// ### psg_delay_timer.sv
// Millisecond delay timer for one rail-pair enable edge
`timescale 1ns/10ps
module psg_delay_timer #(
  parameter int CYCLES_PER_MS = psg_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rstn_i,
  // Control
  input  wire logic                    start_i,
  input  wire logic [psg_pkg::MS_W-1:0] ms_i,
  // Status
  output logic                         done_o
);
  logic [psg_pkg::TICK_W-1:0] tick;
  logic [psg_pkg::MS_W-1:0]   ms_left;
  logic                       running;

  localparam logic [psg_pkg::TICK_W-1:0] TICK_LAST =
    psg_pkg::TICK_W'(CYCLES_PER_MS - 1);

  wire tick_wrap = running && (tick == TICK_LAST);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick    <= '0;
      ms_left <= '0;
      running <= 1'b0;
      done_o  <= 1'b0;
    end else if (start_i) begin
      // Restart aborts a pending count; zero delay finishes next cycle
      tick    <= '0;
      ms_left <= ms_i;
      running <= (ms_i != '0);
      done_o  <= (ms_i == '0);
    end else begin
      done_o <= 1'b0;
      if (running) begin
        tick <= tick_wrap ? '0 : tick + 1'b1;
        if (tick_wrap) begin
          ms_left <= ms_left - 1'b1;
          if (ms_left == 7'h01) begin
            running <= 1'b0;
            done_o  <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### psg_host_model.sv
// Host model that issues register writes over the bank's register port
`timescale 1ns/10ps
module psg_host_model (
  // Requests from the bench
  input  wire logic       req_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] data_i,
  // Register port towards the bank
  output logic            reg_wr_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o
);
  logic bad;
  // Bank never screens these, so the host must
  assign bad = addr_i == 8'h5F && (data_i[6:0] inside {7'h00, 7'h08, 7'h38} ||
               data_i[6:3] == 4'hF);
  assign reg_wr_o    = req_i && !bad;
  assign reg_addr_o  = addr_i;
  assign reg_wdata_o = data_i;
endmodule

// ### psg_pkg.sv
// Register map, field layout and timing constants of the sequencing config bank
package psg_pkg;
  // Register offsets (8-bit register addresses of the config bank)
  localparam logic [7:0] ADDR_PAIR_DELAY   = 8'h27;
  localparam logic [7:0] ADDR_SLEEP_SELECT = 8'h29;
  localparam logic [7:0] ADDR_OUTPUT_MODE  = 8'h2A;
  localparam logic [7:0] ADDR_TARGET_CFG   = 8'h5F;

  // Field positions
  localparam int FALL_LSB     = 3;
  localparam int RISE_LSB     = 0;
  localparam int DELAY_W      = 3;
  localparam int SRC_LSB      = 4;
  localparam int DRIVE_LSB    = 0;
  localparam int ADDR_SEL_BIT = 7;

  // Fixed default target address
  localparam logic [6:0] DEFAULT_TARGET = 7'h5E;

  // Delay table in milliseconds, indexed by the three-bit code
  localparam int DELAY_MS_0 = 0;
  localparam int DELAY_MS_1 = 2;
  localparam int DELAY_MS_2 = 4;
  localparam int DELAY_MS_3 = 8;
  localparam int DELAY_MS_4 = 16;
  localparam int DELAY_MS_5 = 24;
  localparam int DELAY_MS_6 = 32;
  localparam int DELAY_MS_7 = 64;

  // Clock rate and derived tick of one millisecond
  localparam int CLK_HZ        = 20_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int TICK_W        = 15;
  localparam int MS_W          = 7;

  typedef enum logic [1:0] {
    PSG_OFF     = 2'b00,
    PSG_RISE_WT = 2'b01,
    PSG_ON      = 2'b11,
    PSG_FALL_WT = 2'b10
  } psg_state_t;
endpackage

// ### tb_psg_config_bank.sv
// Self-checking bench for the config bank
`timescale 1ns/10ps
module tb_psg_config_bank;
  localparam int CPM = 8;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       nvl = 1'b0;
  logic       req = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] d = 8'h00;
  logic       pe = 1'b0;
  logic       c3 = 1'b0;
  logic       c6 = 1'b0;
  logic [3:0] pg = 4'h0;
  logic [3:0] hv = 4'h0;
  logic       wr, en;
  logic [7:0] wa, wd, rd, slp;
  logic [3:0] go, goe;
  logic [6:0] ta;
  int         n_fail = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  always #25 clk = ~clk;
  psg_host_model host (.req_i(req), .addr_i(a), .data_i(d), .reg_wr_o(wr), .reg_addr_o(wa),
    .reg_wdata_o(wd));
  psg_config_bank #(.CYCLES_PER_MS(CPM)) dut (.sys_clk_i(clk), .rstn_i(rstn), .nv_load_i(nvl),
    .nv_pair_delay_i(d), .nv_sleep_select_i(d), .nv_output_mode_i(d), .nv_target_cfg_i(d),
    .reg_wr_i(wr), .reg_addr_i(wa), .reg_wdata_i(wd), .reg_rdata_o(rd), .reg_hit_o(),
    .pair_enable_i(pe), .switch_ldo_rail_pair_en_o(en), .control_input_three_i(c3),
    .control_input_six_i(c6), .rail_sleep_o(slp), .power_good_i(pg), .host_out_value_i(hv),
    .general_out_o(go), .general_out_oe_o(goe), .target_address_o(ta));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    req <= 1'b1;
    a <= ad;
    d <= dt;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    a <= ad;
    repeat (2) @(posedge clk);
    #1;
    chk("rdata", rd, exp);
  endtask
  task automatic t_regs();
    wr_reg(8'h27, 8'hC5);
    wr_reg(8'h2A, 8'h08);
    wr_reg(8'h28, 8'hFF);
    rd_chk(8'h27, 8'hC5);
    rd_chk(8'h2A, 8'h08);
    rd_chk(8'h28, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_sleep();
    wr_reg(8'h29, 8'hA5);
    c3 <= 1'b1;
    settle();
    chk("sleep", slp, 8'h5A);
    @(posedge clk);
    c3 <= 1'b0;
    c6 <= 1'b1;
    settle();
    chk("sleep", slp, 8'hA5);
    @(posedge clk);
    c3 <= 1'b1;
    settle();
    chk("sleep", slp, 8'hFF);
    $display("test sleep done");
  endtask
  task automatic t_gpo();
    wr_reg(8'h2A, 8'hF0);
    pg <= 4'h5;
    hv <= 4'hA;
    settle();
    chk("gpo", {4'h0, go}, 8'h0A);
    chk("oe", {4'h0, goe}, 8'h0F);
    wr_reg(8'h2A, 8'h00);
    settle();
    chk("gpo", {4'h0, go}, 8'h05);
    wr_reg(8'h2A, 8'h07);
    settle();
    chk("oe", {4'h0, goe}, 8'h0A);
    $display("test gpo done");
  endtask
  task automatic t_addr();
    wr_reg(8'h5F, 8'h85);
    settle();
    chk("taddr", {1'b0, ta}, 8'h05);
    wr_reg(8'h5F, 8'hB8);
    settle();
    chk("taddr", {1'b0, ta}, 8'h05);
    wr_reg(8'h5F, 8'hF8);
    settle();
    chk("taddr", {1'b0, ta}, 8'h05);
    wr_reg(8'h5F, 8'h05);
    settle();
    chk("taddr", {1'b0, ta}, 8'h5E);
    $display("test addr done");
  endtask
  // Window allows for edge detect and state latency
  task automatic t_delay();
    int n;
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h27, {2'b00, c[2:0], c[2:0]});
      pe <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (en !== 1'b1 && n < 700);
      chk("rise", {7'h0, n > ms[c] * CPM && n <= ms[c] * CPM + 7}, 8'h01);
      @(posedge clk);
      pe <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (en !== 1'b0 && n < 700);
      chk("fall", {7'h0, n > ms[c] * CPM && n <= ms[c] * CPM + 7}, 8'h01);
    end
    $display("test delay done");
  endtask
  // Opposite edge inside a wait returns to the prior state
  task automatic t_cancel();
    int n;
    wr_reg(8'h27, 8'h09);
    pe <= 1'b1;
    repeat (4) @(posedge clk);
    pe <= 1'b0;
    n = 0;
    repeat (3 * CPM + 8) begin
      @(posedge clk);
      #1;
      if (en !== 1'b0) n++;
    end
    chk("rise cancel", 8'(n), 8'h00);
    @(posedge clk);
    pe <= 1'b1;
    repeat (3 * CPM + 8) @(posedge clk);
    pe <= 1'b0;
    repeat (4) @(posedge clk);
    pe <= 1'b1;
    n = 0;
    repeat (3 * CPM + 8) begin
      @(posedge clk);
      #1;
      if (en !== 1'b1) n++;
    end
    chk("fall cancel", 8'(n), 8'h00);
    $display("test cancel done");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    d <= 8'h3C;
    nvl <= 1'b1;
    @(posedge clk);
    nvl <= 1'b0;
    rd_chk(8'h29, 8'h3C);
    chk("taddr", {1'b0, ta}, 8'h5E);
    t_regs();
    t_sleep();
    t_gpo();
    t_addr();
    t_delay();
    t_cancel();
    final_report();
  end
endmodule
